// ### hw/fsq_pkg.sv
// Purpose: constants and types for the set-up init and command history block
// Assumes: 16-bit register port, byte addresses as printed
// Notes:   the command engine lies outside this block
package fsq_pkg;
   localparam int            FSQ_ADDR_W          = 8;
   localparam int            FSQ_DATA_W          = 16;
   localparam logic [7:0]    FSQ_SETUP_INIT_OFS  = 8'h8C;
   localparam logic [7:0]    FSQ_CMD_HIST_OFS    = 8'hA0;
   localparam logic [15:0]   FSQ_SETUP_INIT_RST  = 16'h0000;
   localparam logic [15:0]   FSQ_CMD_HIST_RST    = 16'hFFFF;
   localparam logic [7:0]    FSQ_INIT_KEY        = 8'h2D;
   localparam int            FSQ_KEY_MSB         = 15;
   localparam int            FSQ_KEY_LSB         = 8;
   localparam int            FSQ_INIT_BIT        = 0;
   localparam int            FSQ_BYTE_HI_MSB     = 15;
   localparam int            FSQ_BYTE_HI_LSB     = 8;
   localparam int            FSQ_BYTE_LO_MSB     = 7;
   localparam int            FSQ_BYTE_LO_LSB     = 0;
   localparam logic [15:0]   FSQ_READ_ZERO       = 16'h0000;
   // final code of every two-code command
   localparam logic [7:0]    FSQ_CMD_FINAL       = 8'hD0;

   // one-cycle report from the command engine of an accepted command
   typedef struct packed {
      logic       valid;
      logic       two_code;
      logic [7:0] code;
   } fsq_cmd_type;

   // register port request
   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [FSQ_ADDR_W-1:0] addr;
      logic [FSQ_DATA_W-1:0] wdata;
   } fsq_bus_type;
endpackage

// ### hw/fsq_setup_hist.sv
// Purpose: key-protected set-up init register and command history register
// Assumes: command engine reports accepted commands and its busy window
// Notes:   outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none

module fsq_setup_hist (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst_b,
   // register port
   input  wire fsq_pkg::fsq_bus_type bus,
   output var  logic [15:0]     rdata,
   // command engine
   input  wire fsq_pkg::fsq_cmd_type cmd,
   input  wire logic            cmd_busy,
   input  wire logic            cmd_locked,
   // set-up register initialize
   output var  logic            setup_init_pulse
);
   import fsq_pkg::*;

   // stored state
   logic                  setup_init_bit_reg;
   logic [7:0]            latest_cmd_code_reg;
   logic [7:0]            previous_cmd_code_reg;

   // register port decode
   logic                  sel_setup_init;
   logic                  wr_setup_init;
   logic                  key_match;
   logic                  init_allowed;
   logic                  init_write;
   logic                  init_one;

   // command report decode
   logic                  cmd_single;
   logic                  cmd_double;

   // byte address match
   function automatic logic hit(
      input logic [FSQ_ADDR_W-1:0] a,
      input logic [FSQ_ADDR_W-1:0] ofs
   );
      hit = (a == ofs);
   endfunction

   // key byte only gates the write; nothing of it is kept
   function automatic logic key_ok(
      input logic [FSQ_DATA_W-1:0] w
   );
      key_ok = (w[FSQ_KEY_MSB:FSQ_KEY_LSB] == FSQ_INIT_KEY);
   endfunction

   // read-back word; key and reserved bits are never placed, so they read zero
   function automatic logic [FSQ_DATA_W-1:0] read_word(
      input logic [FSQ_ADDR_W-1:0] a,
      input logic                  init_bit,
      input logic [7:0]            latest,
      input logic [7:0]            previous
   );
      logic [FSQ_DATA_W-1:0] w;
      w = FSQ_READ_ZERO;
      case (a)
         FSQ_SETUP_INIT_OFS: begin
            w[FSQ_INIT_BIT] = init_bit;
         end
         FSQ_CMD_HIST_OFS: begin
            w[FSQ_BYTE_HI_MSB:FSQ_BYTE_HI_LSB] = latest;
            w[FSQ_BYTE_LO_MSB:FSQ_BYTE_LO_LSB] = previous;
         end
         default: begin
            w = FSQ_READ_ZERO;
         end
      endcase
      read_word = w;
   endfunction

   // register port decode
   assign sel_setup_init = hit(bus.addr, FSQ_SETUP_INIT_OFS);
   assign wr_setup_init  = bus.wr && sel_setup_init;
   assign key_match      = key_ok(bus.wdata);

   // busy spans first command write to ready rising; lock state re-opens writes
   assign init_allowed   = !cmd_busy || cmd_locked;
   assign init_write     = wr_setup_init && key_match && init_allowed;
   assign init_one       = init_write && bus.wdata[FSQ_INIT_BIT];

   // one report per command; two-code ones carry the first code, the final code is fixed
   assign cmd_single     = cmd.valid && !cmd.two_code;
   assign cmd_double     = cmd.valid && cmd.two_code;

   // init bit keeps the last accepted value; refused writes leave it alone
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         setup_init_bit_reg <= FSQ_SETUP_INIT_RST[FSQ_INIT_BIT];
      end else if (init_write) begin
         setup_init_bit_reg <= bus.wdata[FSQ_INIT_BIT];
      end
   end

   // pulse each accepted write of one; writing zero leaves set-up alone
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         setup_init_pulse <= 1'b0;
      end else begin
         setup_init_pulse <= init_one;
      end
   end

   // history has no write path at all, so software writes are dropped
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         latest_cmd_code_reg <= FSQ_CMD_HIST_RST[FSQ_BYTE_HI_MSB:FSQ_BYTE_HI_LSB];
      end else if (cmd_double) begin
         latest_cmd_code_reg <= FSQ_CMD_FINAL;
      end else if (cmd_single) begin
         latest_cmd_code_reg <= cmd.code;
      end
   end

   // a two-code command overwrites the older byte instead of shifting it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         previous_cmd_code_reg <= FSQ_CMD_HIST_RST[FSQ_BYTE_LO_MSB:FSQ_BYTE_LO_LSB];
      end else if (cmd_double) begin
         previous_cmd_code_reg <= cmd.code;
      end else if (cmd_single) begin
         previous_cmd_code_reg <= latest_cmd_code_reg;
      end
   end

   // read data stand in the cycle after each cycle with bus.rd, zero otherwise
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata <= FSQ_READ_ZERO;
      end else if (bus.rd) begin
         rdata <= read_word(bus.addr, setup_init_bit_reg, latest_cmd_code_reg, previous_cmd_code_reg);
      end else begin
         rdata <= FSQ_READ_ZERO;
      end
   end
endmodule

`default_nettype wire

// ### test/fsq_checker.sv
// Purpose: port assertions for fsq_setup_hist
// Assumes: one clock, sync reset
// Notes: byte shift also checked in bench
`timescale 1ns/1ps
`default_nettype none
module fsq_checker (
   input wire logic mclk,
   input wire logic rst_b,
   input wire fsq_pkg::fsq_bus_type bus,
   input wire logic [15:0] rdata,
   input wire fsq_pkg::fsq_cmd_type cmd,
   input wire logic cmd_busy,
   input wire logic cmd_locked,
   input wire logic setup_init_pulse
);
   logic go;
   assign go = bus.wr && bus.addr == 8'h8C && bus.wdata[15:8] == 8'h2D && bus.wdata[0] && (!cmd_busy || cmd_locked);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_init_go: assert property (go |=> setup_init_pulse) else $error("init pulse missing");
   a_init_cause: assert property (setup_init_pulse |-> $past(go)) else $error("pulse without keyed write");
   a_init_zero: assert property (bus.rd && bus.addr == 8'h8C |=> rdata[15:1] == 15'h0000) else $error("init bits");
   a_rd_unmap: assert property (bus.rd && bus.addr != 8'h8C && bus.addr != 8'hA0 |=> rdata == 16'h0000) else $error("unmapped");
   a_rd_quiet: assert property (!$past(bus.rd) |-> rdata == 16'h0000) else $error("rdata outside read");
   a_hist_one: assert property (cmd.valid && !cmd.two_code ##1 bus.rd && bus.addr == 8'hA0 |=> rdata[15:8] == $past(cmd.code, 2)) else $error("latest");
   a_hist_two: assert property (cmd.valid && cmd.two_code ##1 bus.rd && bus.addr == 8'hA0 |=> rdata == {8'hD0, $past(cmd.code, 2)}) else $error("two code");
   a_hist_shift: assert property (cmd.valid && !cmd.two_code ##1 cmd.valid && !cmd.two_code ##1 bus.rd && bus.addr == 8'hA0 |=> rdata == {$past(cmd.code, 2), $past(cmd.code, 3)}) else $error("shift");
endmodule
bind fsq_setup_hist fsq_checker i_chk (.mclk, .rst_b, .bus, .rdata, .cmd, .cmd_busy, .cmd_locked, .setup_init_pulse);
`default_nettype wire

// ### test/tb_top.sv
// Purpose: random and corner test of fsq_setup_hist
// Assumes: bench drives all ports
// Notes: pulse and history predicted here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fsq_pkg::*;
   logic mclk, rst_b, bz, lk, pls, ib, ok;
   logic [15:0] rdata, d;
   logic [7:0] lat, prv;
   fsq_bus_type b;
   fsq_cmd_type c;
   int fail_count, comparisons, cyc, k, seed;
   logic [7:0] cd [16] = '{8'hE8, 8'hED, 8'hEA, 8'hB0, 8'hD0, 8'h50, 8'hB3, 8'h45, 8'h85,
                           8'h20, 8'h23, 8'h71, 8'h47, 8'h87, 8'h83, 8'h89};
   fsq_setup_hist i_dut (.mclk(mclk), .rst_b(rst_b), .bus(b), .rdata(rdata), .cmd(c),
                         .cmd_busy(bz), .cmd_locked(lk), .setup_init_pulse(pls));
   // an init write counts only with the key and outside a running command, or while the engine is locked
   function automatic logic init_ok(input logic [15:0] w, input logic busy, input logic locked);
      return w[15:8] == 8'h2D && (!busy || locked);
   endfunction
   // history word after one accepted command
   function automatic logic [15:0] hist_after(input logic [15:0] h, input logic two, input logic [7:0] code);
      return two ? {8'hD0, code} : {code, h[15:8]};
   endfunction
   task chk_pls(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk) b <= '{1'b1, 1'b0, a, v};
      @(posedge mclk) b.wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk) b <= '{1'b0, 1'b1, a, 16'h0000};
      c.valid <= 1'b0;
      @(posedge mclk) b.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task cm(input int i);
      @(posedge mclk) c <= '{1'b1, i > 8, cd[i]};
      {lat, prv} = hist_after({lat, prv}, i > 8, cd[i]);
   endtask
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (++cyc > 3000) begin
      fail_count++;
      end_sim();
   end
   initial begin
      {rst_b, bz, lk, b, c, ib, lat, prv} = '0;
      {lat, prv} = 16'hFFFF;
      seed = 32'hdccb;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      rd(8'h8C, 16'h0000);
      rd(8'hA0, 16'hFFFF);
      wr(8'hA0, 16'h0000);
      rd(8'hA0, 16'hFFFF);
      rd(8'h44, 16'h0000);
      for (k = 0; k < 24; k++) begin
         d = 16'($random(seed));
         d[7:1] = 7'h00;
         if (k[2]) d[15:8] = 8'h2D;
         ok = init_ok(d, k[1], k[0]);
         @(posedge mclk) {bz, lk} <= k[1:0];
         wr(8'h8C, d);
         chk_pls(pls, ok && d[0]);
         if (ok) ib = d[0];
         rd(8'h8C, {15'h0000, ib});
      end
      @(posedge mclk) {bz, lk} <= 2'b00;
      for (k = 0; k < 40; k++) begin
         cm(k % 16);
         cm($unsigned($random(seed)) % 16);
         rd(8'hA0, {lat, prv});
      end
      // set the init bit, then reset in mid-run with history filled
      wr(8'h8C, 16'h2D01);
      chk_pls(pls, 1'b1);
      rd(8'h8C, 16'h0001);
      @(posedge mclk) rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      ib = 1'b0;
      {lat, prv} = 16'hFFFF;
      rd(8'h8C, 16'h0000);
      rd(8'hA0, {lat, prv});
      end_sim();
   end
endmodule
`default_nettype wire
